// ---- src/tfc_pkg.sv ----
// Package for the trace filter configuration register bank.
// Assumes a 32-bit AHB-Lite register bus and a single 50 MHz clock.
package tfc_pkg;
  localparam logic [7:0]  TFC_OFF_CCTHR   = 8'h00;
  localparam logic [7:0]  TFC_OFF_SRCID   = 8'h04;
  localparam logic [7:0]  TFC_OFF_IFCTL   = 8'h08;
  localparam logic [7:0]  TFC_OFF_ENABLE  = 8'h0c;
  localparam logic [7:0]  TFC_OFF_STATUS  = 8'h10;
  localparam int          TFC_THR_W       = 12;
  localparam int          TFC_ID_W        = 7;
  localparam int          TFC_EVT_W       = 8;
  localparam int          TFC_EVT_LSB     = 0;
  localparam int          TFC_SS_BIT      = 9;
  localparam int          TFC_RST_BIT     = 10;
  localparam int          TFC_ERR_BIT     = 11;
  localparam int          TFC_LVL_THREAD  = 16;
  localparam int          TFC_LVL_HANDLER = 19;
  localparam int          TFC_EN_BIT      = 0;
  localparam int          TFC_IDLE_BIT    = 0;
  localparam int          TFC_PMS_BIT     = 1;
  localparam logic [11:0] TFC_THR_RESET   = 12'h004;
  localparam logic [6:0]  TFC_ID_RESET    = 7'h01;
  localparam logic [1:0]  TFC_HTRANS_NSEQ = 2'h2;
  localparam logic [1:0]  TFC_HTRANS_SEQ  = 2'h3;
  localparam logic [2:0]  TFC_HSIZE_WORD  = 3'h2;
endpackage

// ---- src/tfc_cc_timer.sv ----
// Cycle count packet spacing timer.
// Assumes the threshold is held stable while tracing is enabled.
`timescale 1ns/1ps
`default_nettype none
module tfc_cc_timer
  import tfc_pkg::*;
(
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 run_i,
  input  wire logic                 want_i,
  input  wire logic [TFC_THR_W-1:0] threshold_i,
  output logic                      emit_o
);
  logic [TFC_THR_W-1:0] gap;

  // Gap counts cycles since the last packet; emission waits for the threshold
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !run_i) begin
      gap    <= '0;
      emit_o <= 1'b0;
    end else if (want_i && gap >= threshold_i) begin
      gap    <= '0;
      emit_o <= 1'b1;
    end else begin
      emit_o <= 1'b0;
      if (gap != {TFC_THR_W{1'b1}}) begin
        gap <= gap + 12'h001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- src/tfc_regs.sv ----
// Trace filter configuration registers with AHB-Lite slave and filter decision.
// Assumes a single AHB-Lite master, word transfers, and trace inputs on clock_i.
//
// Function
// - Threshold sets least gap between count packets
// - Config writes ignored while trace enabled
// - Seven-bit id driven onto trace bus
// - Filter reads trusted when stable flag set
// - Secure level bits enable trace per level
// - Bit16 thread, bit19 handler, middle reserved
// - Force bit always traces system error
// - Force bit traces reset exception, except when a system error arrives in the same cycle
// - Start/stop state bit, set by write
// - Eight-bit event selector qualifies tracing
`timescale 1ns/1ps
`default_nettype none
module tfc_regs
  import tfc_pkg::*;
(
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic      [31:0]          hrdata_o,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  input  wire logic                 insn_valid_i,
  input  wire logic                 insn_handler_i,
  input  wire logic                 insn_secure_i,
  input  wire logic                 exc_syserr_i,
  input  wire logic                 exc_reset_i,
  input  wire logic [255:0]         events_i,
  input  wire logic                 start_hit_i,
  input  wire logic                 stop_hit_i,
  input  wire logic                 cc_want_i,
  output logic                      trace_insn_o,
  output logic                      cc_emit_o,
  output logic      [TFC_ID_W-1:0]  source_id_value_o,
  output logic                      trace_enabled_o
);
  typedef enum logic [1:0] {TFC_IDLE, TFC_RUN, TFC_DRAIN} tfc_state_t;

  logic [TFC_THR_W-1:0] cycle_count_threshold;
  logic [TFC_ID_W-1:0]  source_id_value;
  logic [TFC_EVT_W-1:0] event_select;
  logic                 start_stop_state;
  logic                 force_syserr_trace;
  logic                 force_reset_exc_trace;
  logic                 trace_enable;
  logic                 prev_traced;
  logic                 cc_emit;
  tfc_state_t           state;
  tfc_state_t           next_state;

  logic                 wr_pend;
  logic [7:0]           wr_addr;
  logic                 acc_ok;
  logic                 cfg_write;
  logic                 programmers_model_stable;
  logic                 unit_idle;
  logic [31:0]          filter_word;
  logic [31:0]          next_rdata;
  logic                 level_ok;
  logic                 event_hit;
  logic                 view_now;
  logic                 next_traced;
  logic                 wr_ccthr;
  logic                 wr_srcid;
  logic                 wr_ifctl;
  logic                 wr_enable;
  wire  logic [3:0]     secure_level_enables;

  // Only whole-word transfers are decoded; other sizes are answered but do nothing
  assign acc_ok = hsel_i && hready_i && htrans_i[1] && hsize_i == TFC_HSIZE_WORD;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_pend <= 1'b0;
    end else if (hready_i) begin
      wr_pend <= acc_ok && hwrite_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_addr <= 8'h00;
    end else if (hready_i) begin
      wr_addr <= haddr_i[7:0];
    end
  end

  // Write targets decoded once from the latched address phase
  assign wr_ccthr  = wr_pend && wr_addr == TFC_OFF_CCTHR;
  assign wr_srcid  = wr_pend && wr_addr == TFC_OFF_SRCID;
  assign wr_ifctl  = wr_pend && wr_addr == TFC_OFF_IFCTL;
  assign wr_enable = wr_pend && wr_addr == TFC_OFF_ENABLE;

  // Zero wait states; response is always OKAY
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      hreadyout_o <= 1'b1;
    end else begin
      hreadyout_o <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
    end
  end

  // Configuration is frozen unless the unit is fully idle
  assign cfg_write = wr_pend && state == TFC_IDLE && !trace_enable;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cycle_count_threshold <= TFC_THR_RESET;
    end else if (cfg_write && wr_ccthr) begin
      cycle_count_threshold <= hwdata_i[TFC_THR_W-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      source_id_value <= TFC_ID_RESET;
    end else if (cfg_write && wr_srcid) begin
      source_id_value <= hwdata_i[TFC_ID_W-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      event_select <= 8'h00;
    end else if (cfg_write && wr_ifctl) begin
      event_select <= hwdata_i[TFC_EVT_LSB +: TFC_EVT_W];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      force_syserr_trace <= 1'b0;
    end else if (cfg_write && wr_ifctl) begin
      force_syserr_trace <= hwdata_i[TFC_ERR_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      force_reset_exc_trace <= 1'b0;
    end else if (cfg_write && wr_ifctl) begin
      force_reset_exc_trace <= hwdata_i[TFC_RST_BIT];
    end
  end

  // Only thread and handler levels exist; the middle enables are tied low
  for (genvar lvl = 0; lvl < 4; lvl++) begin : g_level
    if (lvl == 0 || lvl == 3) begin : g_impl
      logic level_en;
      always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
          level_en <= 1'b0;
        end else if (cfg_write && wr_ifctl) begin
          level_en <= hwdata_i[TFC_LVL_THREAD + lvl];
        end
      end
      assign secure_level_enables[lvl] = level_en;
    end else begin : g_res0
      assign secure_level_enables[lvl] = 1'b0;
    end
  end

  // Start/stop state: written while idle, then moved by start and stop hits
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      start_stop_state <= 1'b0;
    end else if (cfg_write && wr_ifctl) begin
      start_stop_state <= hwdata_i[TFC_SS_BIT];
    end else if (state == TFC_RUN) begin
      if (start_hit_i) begin
        start_stop_state <= 1'b1;
      end else if (stop_hit_i) begin
        start_stop_state <= 1'b0;
      end
    end
  end

  // Enable register is always writable, so software can stop tracing
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      trace_enable <= 1'b0;
    end else if (wr_enable) begin
      trace_enable <= hwdata_i[TFC_EN_BIT];
    end
  end

  // One drain cycle after disable lets the last trace decision settle
  always_comb begin
    next_state = state;
    case (state)
      TFC_IDLE: begin
        if (trace_enable) begin
          next_state = TFC_RUN;
        end
      end
      TFC_RUN: begin
        if (!trace_enable) begin
          next_state = TFC_DRAIN;
        end
      end
      TFC_DRAIN: begin
        next_state = TFC_IDLE;
      end
      default: begin
        next_state = TFC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state <= TFC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign unit_idle = state == TFC_IDLE;
  // Filter readback only steady when the start/stop logic cannot move
  assign programmers_model_stable = unit_idle && !trace_enable;

  // Reserved positions are built as zero
  always_comb begin
    filter_word                   = 32'h0000_0000;
    filter_word[TFC_EVT_LSB +: TFC_EVT_W] = event_select;
    filter_word[TFC_SS_BIT]       = start_stop_state;
    filter_word[TFC_RST_BIT]      = force_reset_exc_trace;
    filter_word[TFC_ERR_BIT]      = force_syserr_trace;
    filter_word[TFC_LVL_HANDLER:TFC_LVL_THREAD] = secure_level_enables;
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (haddr_i[7:0])
      TFC_OFF_CCTHR:  next_rdata = {20'h00000, cycle_count_threshold};
      TFC_OFF_SRCID:  next_rdata = {25'h0000000, source_id_value};
      TFC_OFF_IFCTL:  next_rdata = filter_word;
      TFC_OFF_ENABLE: next_rdata = {31'h00000000, trace_enable};
      TFC_OFF_STATUS: next_rdata = {30'h00000000, programmers_model_stable, unit_idle};
      default:        next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (acc_ok && !hwrite_i) begin
      hrdata_o <= next_rdata;
    end
  end

  // Secure level gate; non-secure code is outside this filter
  assign level_ok  = insn_secure_i &&
                     (insn_handler_i ? secure_level_enables[3] : secure_level_enables[0]);
  assign event_hit = events_i[event_select];
  assign view_now  = event_hit && start_stop_state && level_ok;

  // Forced exceptions bypass the filter, except a forced reset exception during a system error; unforced ones follow the previous decision
  always_comb begin
    next_traced = view_now;
    if (exc_syserr_i) begin
      next_traced = force_syserr_trace || prev_traced;
    end else if (exc_reset_i) begin
      next_traced = force_reset_exc_trace || prev_traced;
    end
  end

  // Last decision survives idle cycles, for unforced exceptions
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || state != TFC_RUN) begin
      prev_traced <= 1'b0;
    end else if (insn_valid_i || exc_syserr_i || exc_reset_i) begin
      prev_traced <= next_traced;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || state != TFC_RUN) begin
      trace_insn_o <= 1'b0;
    end else if (insn_valid_i || exc_syserr_i || exc_reset_i) begin
      trace_insn_o <= next_traced;
    end else begin
      trace_insn_o <= 1'b0;
    end
  end

  tfc_cc_timer u_cc_timer (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .run_i       (state == TFC_RUN),
    .want_i      (cc_want_i),
    .threshold_i (cycle_count_threshold),
    .emit_o      (cc_emit)
  );

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cc_emit_o <= 1'b0;
    end else begin
      cc_emit_o <= cc_emit;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      source_id_value_o <= TFC_ID_RESET;
    end else begin
      source_id_value_o <= source_id_value;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      trace_enabled_o <= 1'b0;
    end else begin
      trace_enabled_o <= state == TFC_RUN;
    end
  end
endmodule
`default_nettype wire

// ---- sim/tfc_regs_asserts.sv ----
// Checker for the trace filter register bank.
// Assumes it is bound to tfc_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tfc_regs_asserts
  import tfc_pkg::*;
(
  input wire logic                clock_i,
  input wire logic                rst_n_i,
  input wire logic                hsel_i,
  input wire logic [31:0]         haddr_i,
  input wire logic [1:0]          htrans_i,
  input wire logic                hwrite_i,
  input wire logic                hready_i,
  input wire logic [31:0]         hrdata_o,
  input wire logic                hreadyout_o,
  input wire logic                hresp_o,
  input wire logic                insn_valid_i,
  input wire logic                exc_syserr_i,
  input wire logic                exc_reset_i,
  input wire logic                cc_want_i,
  input wire logic                trace_insn_o,
  input wire logic                cc_emit_o,
  input wire logic [TFC_ID_W-1:0] source_id_value_o,
  input wire logic                trace_enabled_o
);
  logic rd;
  assign rd = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_thr; rd && haddr_i[7:0] == TFC_OFF_CCTHR |=> hrdata_o[31:12] == 20'h0; endproperty
  a_thr: assert property (p_thr) else $error("threshold upper bits set");
  property p_id; rd && haddr_i[7:0] == TFC_OFF_SRCID |=> hrdata_o[31:7] == 25'h0; endproperty
  a_id: assert property (p_id) else $error("id upper bits set");
  property p_flt;
    rd && haddr_i[7:0] == TFC_OFF_IFCTL |=> {hrdata_o[31:20], hrdata_o[18:17], hrdata_o[15:12], hrdata_o[8]} == 19'h0;
  endproperty
  a_flt: assert property (p_flt) else $error("filter reserved bits set");
  property p_trc; trace_insn_o |-> $past(insn_valid_i || exc_syserr_i || exc_reset_i); endproperty
  a_trc: assert property (p_trc) else $error("trace without cause");
  property p_cce; cc_emit_o |-> $past(cc_want_i, 2); endproperty
  a_cce: assert property (p_cce) else $error("count packet not wanted");
  // Threshold resets to four but is not clamped; four quiet cycles follow every packet only while it is four or more
  property p_ccg; cc_emit_o |=> !cc_emit_o [*4]; endproperty
  a_ccg: assert property (p_ccg) else $error("count packets too close");
  property p_hold; trace_enabled_o && $past(trace_enabled_o) |-> $stable(source_id_value_o); endproperty
  a_hold: assert property (p_hold) else $error("id changed while enabled");
  property p_bus; hreadyout_o && !hresp_o; endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or error");
endmodule
bind tfc_regs tfc_regs_asserts tfc_regs_asserts_inst (.clock_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i,
  .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .insn_valid_i, .exc_syserr_i, .exc_reset_i,
  .cc_want_i, .trace_insn_o, .cc_emit_o, .source_id_value_o, .trace_enabled_o);
`default_nettype wire

// ---- sim/tb_top.sv ----
// Testbench for the trace filter register bank.
// Assumes one AHB-Lite master and a 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
  import tfc_pkg::*;
;
  typedef struct {logic [31:0] a, d, e;} tfc_row_t;
  logic clock_i = 0, rst_n_i = 0, hsel_i = 0, hwrite_i = 0, insn_valid_i = 0, insn_handler_i = 0;
  logic insn_secure_i = 1, exc_syserr_i = 0, exc_reset_i = 0, start_hit_i = 0, stop_hit_i = 0, cc_want_i = 0;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, r;
  logic [1:0] htrans_i = 0;
  logic [2:0] hsize_i = 0;
  logic [255:0] events_i = 0;
  logic hreadyout_o, hresp_o, trace_insn_o, cc_emit_o, trace_enabled_o;
  logic [TFC_ID_W-1:0] source_id_value_o;
  wire logic hready_i = hreadyout_o;
  int n_mismatch = 0, checks = 0, k;
  // Unmapped row last, so a decode that aliases it would clobber the source id checked next
  tfc_row_t rows [5] = '{'{32'h00, 32'hffffffff, 32'h00000fff}, '{32'h04, 32'hffffff35, 32'h00000035},
    '{32'h08, 32'hffffffff, 32'h00090eff}, '{32'h00, 32'h00000008, 32'h00000008}, '{32'h14, 32'hffffffff, 32'h0}};
  always #10 clock_i = ~clock_i;
  tfc_regs tfc_regs_inst (.clock_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .insn_valid_i, .insn_handler_i, .insn_secure_i,
    .exc_syserr_i, .exc_reset_i, .events_i, .start_hit_i, .stop_hit_i, .cc_want_i, .trace_insn_o,
    .cc_emit_o, .source_id_value_o, .trace_enabled_o);
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_for(input logic en, input logic v);
    int i;
    i = 0;
    do begin @(posedge clock_i); i++; end
    while ((en ? trace_enabled_o : hreadyout_o) !== v && i < 50);
    if ((en ? trace_enabled_o : hreadyout_o) !== v) begin n_mismatch++; finish_test; end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_i);
    hsel_i <= 1;
    htrans_i <= TFC_HTRANS_NSEQ;
    haddr_i <= a;
    hwrite_i <= w;
    hsize_i <= TFC_HSIZE_WORD;
    wait_for(0, 1);
    hsel_i <= 0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_for(0, 1);
    r = hrdata_o;
  endtask
  task automatic ins(input logic v, input logic h, input logic [1:0] x, input logic e, input logic exp);
    @(posedge clock_i);
    insn_valid_i <= v;
    insn_handler_i <= h;
    {exc_reset_i, exc_syserr_i} <= x;
    events_i[3] <= e;
    @(posedge clock_i);
    insn_valid_i <= 0;
    {exc_reset_i, exc_syserr_i} <= 2'h0;
    #1 `CHK(trace_insn_o, exp)
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1;
    foreach (rows[i]) begin
      bus(1, rows[i].a, rows[i].d);
      bus(0, rows[i].a, 0);
      `CHK(r, rows[i].e)
    end
    `CHK(source_id_value_o, 7'h35)
    $display("register table done");
    bus(1, TFC_OFF_IFCTL, 32'h00010a03);
    bus(1, TFC_OFF_ENABLE, 1);
    wait_for(1, 1);
    bus(0, TFC_OFF_STATUS, 0);
    `CHK(r[TFC_PMS_BIT], 1'b0)
    bus(1, TFC_OFF_SRCID, 32'h22);
    bus(0, TFC_OFF_SRCID, 0);
    `CHK(r, 32'h35)
    ins(1, 0, 2'h0, 1, 1);
    @(posedge clock_i);
    insn_secure_i <= 0;
    ins(1, 0, 2'h0, 1, 0);
    @(posedge clock_i);
    insn_secure_i <= 1;
    ins(1, 1, 2'h0, 1, 0);
    ins(0, 0, 2'h1, 0, 1);
    ins(0, 0, 2'h2, 0, 1);
    ins(1, 0, 2'h0, 0, 0);
    ins(0, 0, 2'h2, 0, 0);
    @(posedge clock_i);
    cc_want_i <= 1;
    k = 0;
    repeat (40) begin @(posedge clock_i); #1 k += int'(cc_emit_o === 1'b1); end
    @(posedge clock_i);
    cc_want_i <= 0;
    `CHK(k >= 4 && k <= 5, 1'b1)
    @(posedge clock_i);
    stop_hit_i <= 1;
    @(posedge clock_i);
    stop_hit_i <= 0;
    ins(1, 0, 2'h0, 1, 0);
    @(posedge clock_i);
    start_hit_i <= 1;
    @(posedge clock_i);
    start_hit_i <= 0;
    ins(1, 0, 2'h0, 1, 1);
    $display("trace filter done");
    bus(1, TFC_OFF_ENABLE, 0);
    wait_for(1, 0);
    repeat (3) @(posedge clock_i);
    bus(0, TFC_OFF_STATUS, 0);
    `CHK(r[TFC_PMS_BIT], 1'b1)
    bus(1, TFC_OFF_SRCID, 32'h22);
    bus(0, TFC_OFF_SRCID, 0);
    `CHK(r, 32'h22)
    rst_n_i <= 0;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1;
    bus(0, TFC_OFF_CCTHR, 0);
    `CHK(r, {20'h0, TFC_THR_RESET})
    bus(0, TFC_OFF_IFCTL, 0);
    `CHK(r, 32'h0)
    `CHK(source_id_value_o, TFC_ID_RESET)
    `CHK(trace_enabled_o, 1'b0)
    $display("reset done");
    finish_test;
  end
endmodule
`default_nettype wire
